// *** fct_params.svh ***
/*
  timing counts, register offsets and field positions of the fixed-cycle
  timer; assumes a 100 MHz system clock.
*/
`ifndef FCT_PARAMS_SVH
`define FCT_PARAMS_SVH

`define FCT_CLK_HZ 100000000
`define FCT_CLK_NS 10
`define FCT_SRC4096_NS 244141
`define FCT_SRC4096_CYC ((`FCT_SRC4096_NS + `FCT_CLK_NS - 1) / `FCT_CLK_NS)
`define FCT_SRC64_CYC (`FCT_CLK_HZ / 64)
`define FCT_SRC1_CYC (`FCT_CLK_HZ)
`define FCT_SRCMIN_CYC (64'(`FCT_CLK_HZ) * 64'h3c)
`define FCT_RTN_FAST_NS 122000
`define FCT_RTN_FAST_CYC (`FCT_RTN_FAST_NS / `FCT_CLK_NS)
`define FCT_RTN_SLOW_NS 7813000
`define FCT_RTN_SLOW_CYC (`FCT_RTN_SLOW_NS / `FCT_CLK_NS)

`define FCT_ADDR_CNT0 4'hb
`define FCT_ADDR_CNT1 4'hc
`define FCT_ADDR_EXT 4'hd
`define FCT_ADDR_FLAG 4'he
`define FCT_ADDR_CTRL 4'hf
`define FCT_ADDR_IRQ_STAT 4'h1
`define FCT_ADDR_IRQ_MASK 4'h2

`define FCT_BIT_RUN 4
`define FCT_BIT_EVT 4
`define FCT_BIT_IEN 4
`define FCT_PRESET_RST 12'h001

`endif

// *** fct_pkg.sv ***
/*
  types shared by the fixed-cycle timer files; no assumptions.
*/
`default_nettype none
package fct_pkg;
  typedef enum logic [1:0] {
    FCT_SRC_4096 = 2'b00,
    FCT_SRC_64 = 2'b01,
    FCT_SRC_1 = 2'b10,
    FCT_SRC_MIN = 2'b11
  } fct_src_t;

  typedef enum logic [1:0] {
    FCT_ST_IDLE = 2'b00,
    FCT_ST_ARM = 2'b01,
    FCT_ST_RUN = 2'b10
  } fct_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fct_bus_t;
endpackage : fct_pkg
`default_nettype wire

// *** fct_tick.sv ***
/*
  source clock tick generator: one pulse per selected source period;
  assumes restart pulses come from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fct_params.svh"

module fct_tick
  import fct_pkg::*;
#(
  parameter int unsigned P4096 = `FCT_SRC4096_CYC,
  parameter int unsigned P64 = `FCT_SRC64_CYC,
  parameter int unsigned P1 = `FCT_SRC1_CYC,
  parameter longint unsigned PMIN = `FCT_SRCMIN_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_restart,
  input wire fct_src_t i_sel,
  output logic o_tick
);
  logic [32:0] cnt_q;
  logic [32:0] period;

  always_comb begin
    case (i_sel)
      FCT_SRC_4096: period = 33'(P4096);
      FCT_SRC_64: period = 33'(P64);
      FCT_SRC_1: period = 33'(P1);
      default: period = 33'(PMIN);
    endcase
  end

  // full period after restart, so first interval never runs long
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 33'h0;
      o_tick <= 1'b0;
    end else if (i_restart) begin
      cnt_q <= 33'h0;
      o_tick <= 1'b0;
    end else if (cnt_q >= period - 33'h1) begin
      cnt_q <= 33'h0;
      o_tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 33'h1;
      o_tick <= 1'b0;
    end
  end
endmodule : fct_tick

`default_nettype wire

// *** fct_timer.sv ***
/*
  fixed-cycle countdown timer with event flag, enable-gated open-drain
  request pin and auto-release; registers over a plain strobe port.
  assumes scl comes from a pin and the bus master is on i_sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fct_params.svh"

// Notes on behaviour
// RULE_01: run bit starts/stops; stop keeps pin low
// RULE_02: each start loads stored preset
// RULE_03: stopped reads return preset
// RULE_04: event sets flag, held until cleared
// RULE_05: writing 0 clears flag, pin kept
// RULE_06: writing 1 to flag does nothing
// RULE_07: enabled event drives request pin low
// RULE_08: disabled leaves pin; enable clear releases
// RULE_09: pin shared with other interrupt sources
// RULE_10: count starts on scl rise after write
// RULE_11: interval is preset times source period
// RULE_12: first interval never longer than set
// RULE_13: select picks period and release time
// RULE_14: event at 1 to 0, then reload
// RULE_15: host writes preset 1..4095 while stopped
// RULE_16: pin self-releases after release time
// RULE_17: running reads show live count
module fct_timer
  import fct_pkg::*;
#(
  parameter int unsigned RTN_FAST = `FCT_RTN_FAST_CYC,
  parameter int unsigned RTN_SLOW = `FCT_RTN_SLOW_CYC,
  parameter int unsigned P4096 = `FCT_SRC4096_CYC,
  parameter int unsigned P64 = `FCT_SRC64_CYC,
  parameter int unsigned P1 = `FCT_SRC1_CYC,
  parameter longint unsigned PMIN = `FCT_SRCMIN_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_scl,
  input wire logic i_other_irq,
  output logic [7:0] o_rdata,
  output logic o_irq_n_out,
  output logic o_irq_n_oe,
  output logic o_irq
);
  fct_bus_t bus;
  logic scl_m_q, scl_s_q, scl_p_q;
  logic scl_rise;
  logic [11:0] preset_q;
  logic [11:0] count_q;
  logic timer_run_bit_q;
  logic timer_event_flag_q;
  logic timer_irq_enable_q;
  logic source_clock_select_hi_q;
  logic source_clock_select_lo_q;
  fct_state_t state_q;
  logic tick;
  logic evt;
  logic pin_low_q;
  logic [22:0] rtn_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  fct_src_t sel;
  logic [11:0] cnt_rd;
  logic [22:0] low_cnt_q;
  fct_src_t low_sel_q;

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign sel = fct_src_t'({source_clock_select_hi_q,
                           source_clock_select_lo_q});
  assign cnt_rd = timer_run_bit_q ? count_q : preset_q; // RULE_03 RULE_17

  function automatic logic wr_at(input fct_bus_t b, input logic [3:0] a);
    wr_at = b.wr && (b.addr == a);
  endfunction : wr_at

  function automatic logic [22:0] rtn_len(input fct_src_t s);
    rtn_len = (s == FCT_SRC_4096) ? 23'(RTN_FAST) : 23'(RTN_SLOW);
  endfunction : rtn_len

  // scl synchroniser and rising edge
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
    end else begin
      scl_m_q <= i_scl;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
    end
  end
  assign scl_rise = scl_s_q && !scl_p_q;

  // control bits
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      timer_run_bit_q <= 1'b0;
      source_clock_select_hi_q <= 1'b0;
      source_clock_select_lo_q <= 1'b0;
      timer_irq_enable_q <= 1'b0;
      preset_q <= `FCT_PRESET_RST;
    end else begin
      if (wr_at(bus, `FCT_ADDR_EXT)) begin
        timer_run_bit_q <= bus.wdata[`FCT_BIT_RUN]; // RULE_01
        source_clock_select_hi_q <= bus.wdata[1]; // RULE_13
        source_clock_select_lo_q <= bus.wdata[0];
      end
      if (wr_at(bus, `FCT_ADDR_CTRL)) begin
        timer_irq_enable_q <= bus.wdata[`FCT_BIT_IEN];
      end
      if (wr_at(bus, `FCT_ADDR_CNT0)) begin
        preset_q[7:0] <= bus.wdata;
      end
      if (wr_at(bus, `FCT_ADDR_CNT1)) begin
        preset_q[11:8] <= bus.wdata[3:0];
      end
    end
  end

  // run sequencing: arm on run, start on next scl rise
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= FCT_ST_IDLE;
    end else begin
      case (state_q)
        FCT_ST_IDLE: begin
          if (timer_run_bit_q) begin
            state_q <= FCT_ST_ARM;
          end
        end
        FCT_ST_ARM: begin
          if (!timer_run_bit_q) begin
            state_q <= FCT_ST_IDLE;
          end else if (scl_rise) begin
            state_q <= FCT_ST_RUN; // RULE_10
          end
        end
        FCT_ST_RUN: begin
          if (!timer_run_bit_q) begin
            state_q <= FCT_ST_IDLE;
          end
        end
        default: state_q <= FCT_ST_IDLE;
      endcase
    end
  end

  fct_tick #(
    .P4096(P4096),
    .P64(P64),
    .P1(P1),
    .PMIN(PMIN)
  ) u_tick (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_restart(state_q != FCT_ST_RUN), // RULE_12
    .i_sel(sel),
    .o_tick(tick)
  );

  assign evt = (state_q == FCT_ST_RUN) && tick && (count_q == 12'h001);

  // down counter
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      count_q <= `FCT_PRESET_RST;
    end else if (state_q != FCT_ST_RUN) begin
      count_q <= preset_q; // RULE_02
    end else if (tick) begin
      if (count_q <= 12'h001) begin
        count_q <= preset_q; // RULE_14 RULE_11
      end else begin
        count_q <= count_q - 12'h001; // RULE_11
      end
    end
  end

  // event flag
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      timer_event_flag_q <= 1'b0;
    end else if (evt) begin
      timer_event_flag_q <= 1'b1; // RULE_04
    end else if (wr_at(bus, `FCT_ADDR_FLAG) &&
                 !bus.wdata[`FCT_BIT_EVT]) begin
      timer_event_flag_q <= 1'b0; // RULE_05 RULE_06
    end
  end

  // request pin with auto-release
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_low_q <= 1'b0;
      rtn_q <= 23'h0;
    end else if (evt && timer_irq_enable_q) begin
      pin_low_q <= 1'b1; // RULE_07
      rtn_q <= rtn_len(sel) - 23'h1;
    end else if (!timer_irq_enable_q) begin
      pin_low_q <= 1'b0; // RULE_08
      rtn_q <= 23'h0;
    end else if (pin_low_q) begin
      if (rtn_q == 23'h0) begin
        pin_low_q <= 1'b0; // RULE_16
      end else begin
        rtn_q <= rtn_q - 23'h1;
      end
    end
  end

  // shared open-drain pin
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq_n_out <= 1'b0;
      o_irq_n_oe <= 1'b0;
    end else begin
      o_irq_n_out <= 1'b0;
      o_irq_n_oe <= pin_low_q || i_other_irq; // RULE_09
    end
  end

  // sticky status, mask, level interrupt
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_stat_q <= 2'h0;
      irq_mask_q <= 2'h0;
      o_irq <= 1'b0;
    end else begin
      irq_stat_q[0] <= evt || (irq_stat_q[0] &&
        !(wr_at(bus, `FCT_ADDR_IRQ_STAT) && bus.wdata[0]));
      irq_stat_q[1] <= (scl_rise && state_q == FCT_ST_ARM) ||
        (irq_stat_q[1] && !(wr_at(bus, `FCT_ADDR_IRQ_STAT) && bus.wdata[1]));
      if (wr_at(bus, `FCT_ADDR_IRQ_MASK)) begin
        irq_mask_q <= bus.wdata[1:0];
      end
      o_irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // read port
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        `FCT_ADDR_CNT0: o_rdata <= cnt_rd[7:0];
        `FCT_ADDR_CNT1: o_rdata <= {4'h0, cnt_rd[11:8]};
        `FCT_ADDR_EXT: o_rdata <= {3'h0, timer_run_bit_q, 2'h0,
                                   source_clock_select_hi_q,
                                   source_clock_select_lo_q};
        `FCT_ADDR_FLAG: o_rdata <= {3'h0, timer_event_flag_q, 4'h0};
        `FCT_ADDR_CTRL: o_rdata <= {3'h0, timer_irq_enable_q, 4'h0};
        `FCT_ADDR_IRQ_STAT: o_rdata <= {6'h0, irq_stat_q};
        `FCT_ADDR_IRQ_MASK: o_rdata <= {6'h0, irq_mask_q};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // cycles the pin has stayed low since it was last set
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      low_cnt_q <= 23'h0;
      low_sel_q <= FCT_SRC_4096;
    end else if (evt && timer_irq_enable_q) begin
      low_cnt_q <= 23'h0;
      low_sel_q <= sel;
    end else if (pin_low_q) begin
      low_cnt_q <= low_cnt_q + 23'h1;
    end
  end

  a_flag_sets: assert property (@(posedge i_sys_clk) // RULE_04
    disable iff (i_rst) evt |=> timer_event_flag_q)
    else $error("flag not set on event");
  a_flag_one_kept: assert property (@(posedge i_sys_clk) // RULE_06
    disable iff (i_rst) timer_event_flag_q &&
    !(wr_at(bus, `FCT_ADDR_FLAG) && !bus.wdata[`FCT_BIT_EVT])
    |=> timer_event_flag_q)
    else $error("flag lost");
  a_flag_clear: assert property (@(posedge i_sys_clk) // RULE_05
    disable iff (i_rst) wr_at(bus, `FCT_ADDR_FLAG) &&
    !bus.wdata[`FCT_BIT_EVT] && !evt |=> !timer_event_flag_q)
    else $error("flag not cleared");
  a_flag_clear_pin: assert property (@(posedge i_sys_clk) // RULE_05
    disable iff (i_rst) wr_at(bus, `FCT_ADDR_FLAG) && pin_low_q &&
    timer_irq_enable_q && rtn_q != 23'h0 |=> pin_low_q)
    else $error("flag clear released pin");
  a_pin_enabled: assert property (@(posedge i_sys_clk) // RULE_07
    disable iff (i_rst) evt && timer_irq_enable_q |=> ##1 o_irq_n_oe)
    else $error("pin not driven");
  a_pin_disabled: assert property (@(posedge i_sys_clk) // RULE_08
    disable iff (i_rst) !timer_irq_enable_q |=> !pin_low_q)
    else $error("pin kept low");
  a_masked_event: assert property (@(posedge i_sys_clk) // RULE_08
    disable iff (i_rst) evt && !timer_irq_enable_q ##1 !i_other_irq
    |=> !o_irq_n_oe)
    else $error("masked event drove pin");
  a_shared_pin: assert property (@(posedge i_sys_clk) // RULE_09
    disable iff (i_rst) i_other_irq |=> o_irq_n_oe && !o_irq_n_out)
    else $error("shared source not passed");
  a_stop_keeps_pin: assert property (@(posedge i_sys_clk) // RULE_01
    disable iff (i_rst) pin_low_q && timer_irq_enable_q &&
    rtn_q != 23'h0 && !timer_run_bit_q |=> pin_low_q)
    else $error("stop released pin");
  a_run_stops: assert property (@(posedge i_sys_clk) // RULE_01
    disable iff (i_rst) !timer_run_bit_q |=> state_q == FCT_ST_IDLE)
    else $error("timer kept running");
  a_start_preset: assert property (@(posedge i_sys_clk) // RULE_02
    disable iff (i_rst) state_q == FCT_ST_ARM && scl_rise &&
    timer_run_bit_q |=> count_q == preset_q)
    else $error("start not from preset");
  a_count_step: assert property (@(posedge i_sys_clk) // RULE_11
    disable iff (i_rst) state_q == FCT_ST_RUN && tick && count_q > 12'h001
    |=> count_q == $past(count_q) - 12'h001)
    else $error("count did not step");
  a_reload: assert property (@(posedge i_sys_clk) // RULE_14
    disable iff (i_rst) evt |=> count_q == preset_q)
    else $error("no reload");
  a_src_select: assert property (@(posedge i_sys_clk) // RULE_13
    disable iff (i_rst) wr_at(bus, `FCT_ADDR_EXT)
    |=> sel == fct_src_t'($past(i_wdata[1:0])))
    else $error("source select not taken");
  a_idle_read: assert property (@(posedge i_sys_clk) // RULE_03
    disable iff (i_rst) bus.rd && bus.addr == `FCT_ADDR_CNT0 &&
    !timer_run_bit_q |=> o_rdata == $past(preset_q[7:0]))
    else $error("bad read");
  a_live_read: assert property (@(posedge i_sys_clk) // RULE_17
    disable iff (i_rst) bus.rd && bus.addr == `FCT_ADDR_CNT0 &&
    timer_run_bit_q |=> o_rdata == $past(count_q[7:0]))
    else $error("live read wrong");
  a_status_sticky: assert property (@(posedge i_sys_clk)
    disable iff (i_rst) irq_stat_q[0] &&
    !(wr_at(bus, `FCT_ADDR_IRQ_STAT) && i_wdata[0]) |=> irq_stat_q[0])
    else $error("status bit lost");
  a_pin_timeout: assert property (@(posedge i_sys_clk) // RULE_16
    disable iff (i_rst) pin_low_q |-> low_cnt_q < rtn_len(low_sel_q))
    else $error("no auto release");
endmodule : fct_timer

`default_nettype wire

// *** fct_host_model.sv ***
/*
  serial clock side of the bus host model: scl idles high and bursts
  nine pulses when asked. assumes the bench writes registers itself.
*/
`timescale 1ns/1ps
`default_nettype none
module fct_host_model #(
  parameter int HALF_NS = 80
) (
  input wire logic i_go,
  output logic o_scl
);
  initial begin
    o_scl = 1'b1;
    forever begin
      @(posedge i_go);
      repeat (9) begin
        #(HALF_NS);
        o_scl = 1'b0;
        #(HALF_NS);
        o_scl = 1'b1;
      end
    end
  end
endmodule : fct_host_model
`default_nettype wire

// *** tb_fixed_cycle_timer_interrupt.sv ***
/*
  self-checking bench of the fixed-cycle timer with shortened counts.
  assumes the host model drives scl and the bench drives the bus.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_fixed_cycle_timer_interrupt;
  import fct_pkg::*;
  localparam int PER[4] = '{8, 16, 32, 64};
  localparam int RTN[4] = '{20, 40, 40, 40};
  localparam logic [3:0] RA[8] = '{4'hb, 4'hc, 4'hd, 4'he, 4'hf, 4'h1,
                                   4'h2, 4'h5};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic other = 1'b0;
  logic go = 1'b0;
  logic scl, nout, oe, irq, hi;
  logic [7:0] rdata, d;
  logic [31:0] seed = 32'h12;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int p, t, w;

  fct_timer #(.RTN_FAST(RTN[0]), .RTN_SLOW(RTN[1]), .P4096(PER[0]),
    .P64(PER[1]), .P1(PER[2]), .PMIN(PER[3])) uut (.i_sys_clk(clk),
    .i_rst(rst),
    .i_addr(addr), .i_wdata(wdata), .i_wr(bus_wr), .i_rd(bus_rd),
    .i_scl(scl), .i_other_irq(other), .o_rdata(rdata),
    .o_irq_n_out(nout), .o_irq_n_oe(oe), .o_irq(irq));
  fct_host_model host (.i_go(go), .o_scl(scl));

  initial begin
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    #1;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 v = rdata;
  endtask : reg_rd

  task automatic wait_oe(input logic v);
    int c;
    c = 0;
    while (oe !== v && c < 3000) begin
      @(posedge clk);
      #1 c++;
    end
    if (c >= 3000) chk("pin wait", 1, 0);
  endtask : wait_oe

  task automatic first(input int s);
    int t0;
    t0 = cyc;
    go = 1'b1;
    wait_oe(1'b1);
    go = 1'b0;
    chk("first gap", 1, (cyc - t0 <= p * PER[s] + 24) &&
        (cyc - t0 >= (p - 1) * PER[s]));
  endtask : first

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      finish_test;
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    reg_wr(4'h5, 8'hff);
    foreach (RA[i]) begin
      reg_rd(RA[i], d);
      chk("reset value", (i == 0) ? 1 : 0, d);
    end
    for (int s = 0; s < 4; s++) begin
      reg_wr(4'hd, 8'h00);
      reg_wr(4'h1, 8'h03);
      reg_rd(4'h1, d);
      chk("status clear", 0, d);
      seed = xs(seed);
      p = 3 + seed % 6;
      reg_wr(4'hc, seed[15:8]);
      reg_rd(4'hc, d);
      chk("preset hi", {4'h0, seed[11:8]}, d);
      reg_wr(4'hc, 8'h00);
      reg_wr(4'hb, p[7:0]);
      reg_rd(4'hb, d);
      chk("preset", p, d);
      reg_wr(4'hf, 8'h10);
      reg_wr(4'h2, 8'h01);
      wait_oe(1'b0);
      reg_wr(4'hd, 8'h10 | 8'(s));
      first(s);
      t = cyc;
      chk("pin level", 0, nout);
      chk("irq out", 1, irq);
      reg_rd(4'he, d);
      chk("flag", 8'h10, d);
      wait_oe(1'b0);
      w = cyc - t;
      chk("release", 1, w <= RTN[s] && w >= RTN[s] - 3);
      wait_oe(1'b1);
      chk("interval", p * PER[s], cyc - t);
      case (s)
        0: begin
          reg_wr(4'he, 8'h10);
          reg_rd(4'he, d);
          chk("flag w1", 8'h10, d);
          reg_wr(4'he, 8'h00);
          chk("pin kept", 1, oe);
          reg_rd(4'he, d);
          chk("flag w0", 0, d);
        end
        1: begin
          reg_wr(4'hd, 8'h00);
          chk("stop kept", 1, oe);
          reg_rd(4'hb, d);
          chk("stopped count", p, d);
          wait_oe(1'b0);
          reg_wr(4'hd, 8'h11);
          first(s);
          repeat (PER[s]) @(posedge clk);
          reg_rd(4'hb, d);
          chk("live count", p - 1, d);
        end
        2: begin
          reg_wr(4'hf, 8'h00);
          repeat (2) @(posedge clk);
          #1 chk("enable off", 0, oe);
          reg_wr(4'he, 8'h00);
          t = cyc;
          hi = 1'b0;
          while (cyc - t < p * PER[s] + 10) begin
            @(posedge clk);
            #1 hi = hi | oe;
          end
          chk("masked pin", 0, hi);
          reg_rd(4'he, d);
          chk("flag again", 8'h10, d);
        end
        default: begin
          reg_wr(4'hf, 8'h00);
          wait_oe(1'b0);
          @(posedge clk);
          other <= 1'b1;
          repeat (3) @(posedge clk);
          #1 chk("shared pin", 1, oe);
          @(posedge clk);
          other <= 1'b0;
        end
      endcase
      reg_rd(4'h1, d);
      chk("status", 8'h03, d);
      reg_wr(4'h2, 8'h00);
      @(posedge clk);
      #1 chk("irq masked", 0, irq);
      $display("source %0d done", s);
    end
    finish_test;
  end
endmodule : tb_fixed_cycle_timer_interrupt
`default_nettype wire
